// ---- inc/sysbus_pkg.sv ----
// Shared constants for the system-bus grant and snoop block
package sysbus_pkg;

  // ----------------------------------------
  // Register port geometry
  // ----------------------------------------
  localparam int REG_AW = 8;
  localparam int REG_DW = 32;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [REG_AW-1:0] MEM_SUBSYS_CONTROL_OFS = 8'h00;
  localparam logic [REG_AW-1:0] BUS_STATUS_OFS = 8'h04;

  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  localparam int CTL_MODE_BIT = 0;
  localparam int CTL_ABD_BIT = 1;
  localparam int CTL_L1_INTV_BIT = 2;
  localparam int CTL_L2_INTV_BIT = 3;
  localparam logic CTL_L1_INTV_RST = 1'h0;
  localparam logic CTL_L2_INTV_RST = 1'h0;

  // ----------------------------------------
  // Status register fields
  // ----------------------------------------
  localparam int STS_TENURE_BIT = 0;
  localparam int STS_INTV_PEND_BIT = 1;
  localparam int STS_ADDR_OE_BIT = 2;
  localparam int STS_REQ_BIT = 3;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  // Start strobe is driven low, then high, then released
  localparam logic [1:0] TS_DRIVE_CYCLES = 2'h2;
  localparam int SYNC_STAGES = 3;

endpackage

// ---- design/pin_sync3.sv ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps

module pin_sync3 #(
  parameter logic RESET_VAL = 1'b1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Pin and filtered level
  input wire logic pin_in,
  output logic level_q
);
  import sysbus_pkg::*;

  logic [SYNC_STAGES-1:0] stage_q;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      stage_q <= {SYNC_STAGES{RESET_VAL}};
    end
    else
    begin
      stage_q <= {stage_q[SYNC_STAGES-2:0], pin_in};
    end
  end

  // First stage feeds only the second; filter looks at stages two and three
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      level_q <= RESET_VAL;
    end
    else if (stage_q[1] == stage_q[2])
    begin
      level_q <= stage_q[2];
    end
  end

endmodule // pin_sync3

// ---- design/snoop_responder.sv ----
// Snoop response in the retry window: intervention, retry, shared
`timescale 1ns/1ps

module snoop_responder (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Configuration
  input wire logic ext_mode,
  input wire logic l1_intv_en,
  input wire logic l2_intv_en,
  // Cache lookup result for a foreign transaction
  input wire logic snoop_valid,
  input wire logic snoop_hit_l1,
  input wire logic snoop_hit_l2,
  input wire logic snoop_modified,
  input wire logic snoop_shared,
  // Bus acknowledge, same clock
  input wire logic address_acknowledge_n,
  // Intervention data beats from the cache
  input wire logic intv_beat_valid,
  input wire logic intv_beat_last,
  // Bus responses
  output logic intervention_hit_n,
  output logic address_retry_o,
  output logic address_retry_oe,
  output logic shared_ind_a_n,
  output logic shared_ind_b_n,
  output logic data_ready_out_n,
  // Cache side
  output logic flush_req,
  output logic intv_pend_q
);
  import sysbus_pkg::*;

  logic held_q;
  logic hit_l1_q;
  logic hit_l2_q;
  logic mod_q;
  logic shr_q;
  logic cur_l1;
  logic cur_l2;
  logic cur_mod;
  logic cur_shr;
  logic window;
  logic intervene;

  // A lookup may land in the acknowledge cycle itself
  assign cur_l1 = snoop_valid ? snoop_hit_l1 : hit_l1_q;
  assign cur_l2 = snoop_valid ? snoop_hit_l2 : hit_l2_q;
  assign cur_mod = snoop_valid ? snoop_modified : mod_q;
  assign cur_shr = snoop_valid ? snoop_shared : shr_q;
  assign window = !address_acknowledge_n && (held_q || snoop_valid);
  assign intervene = ext_mode && ((cur_l1 && l1_intv_en) || (cur_l2 && l2_intv_en));

  // ----------------------------------------
  // Lookup hold until acknowledge
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      held_q <= 1'b0;
      hit_l1_q <= 1'b0;
      hit_l2_q <= 1'b0;
      mod_q <= 1'b0;
      shr_q <= 1'b0;
    end
    else
    begin
      if (snoop_valid)
      begin
        hit_l1_q <= snoop_hit_l1;
        hit_l2_q <= snoop_hit_l2;
        mod_q <= snoop_modified;
        shr_q <= snoop_shared;
      end
      held_q <= window ? 1'b0 : (held_q || snoop_valid);
    end
  end

  // ----------------------------------------
  // Responses, one cycle after acknowledge
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      intervention_hit_n <= 1'b1;
      address_retry_o <= 1'b1;
      address_retry_oe <= 1'b0;
      shared_ind_a_n <= 1'b1;
      shared_ind_b_n <= 1'b1;
      flush_req <= 1'b0;
    end
    else
    begin
      intervention_hit_n <= !(window && intervene);
      address_retry_o <= 1'b0;
      address_retry_oe <= window && !intervene && cur_mod;
      flush_req <= window && !intervene && cur_mod;
      shared_ind_a_n <= !(window && !intervene && cur_shr);
      shared_ind_b_n <= !(window && !intervene && cur_shr && ext_mode);
    end
  end

  // ----------------------------------------
  // Intervention data tenure
  // ----------------------------------------
  // Set wins over the last-beat clear
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      intv_pend_q <= 1'b0;
    end
    else if (window && intervene)
    begin
      intv_pend_q <= 1'b1;
    end
    else if (intv_beat_valid && intv_beat_last)
    begin
      intv_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      data_ready_out_n <= 1'b1;
    end
    else
    begin
      data_ready_out_n <= !(intv_pend_q && intv_beat_valid);
    end
  end

endmodule // snoop_responder

// ---- design/sysbus_grant_snoop.sv ----
// Bus master: mode strap, request and qualified grant, address drive, snoop
`timescale 1ns/1ps

// Contract
// - The strap is sampled at hard reset release; asserted gives extended mode and mode bit 1.
// - In extended mode intervention-hit is driven only in the cycle after address acknowledge.
// - A snoop hit in either cache level gives intervention-hit only if that level is enabled.
// - Data-ready is driven while supplying intervention data for another master after a hit.
// - In extended mode a shared line is signalled on both shared-indication outputs together.
// - In extended mode request drops in the start cycle unless another transaction is pending.
// - Grant qualifies only if asserted with no retry, no start and no blocking internal state.
// - The bus may still be taken in the cycle grant drops if it was qualified the cycle before; here start needs grant in its own cycle.
// - In extended mode the optional monitor output behaves exactly as the legacy busy output.
// - Address-bus-driven mode follows the strap at hard reset release and reads back read-only.
// - With driven and extended mode both set, address drive starts the cycle after grant.
// - Otherwise address drive ends one cycle after acknowledge unless a grant qualified then.
module sysbus_grant_snoop (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Straps
  input wire logic hard_reset_n,
  input wire logic bus_mode_strap_n,
  // Register port
  input wire logic [sysbus_pkg::REG_AW-1:0] reg_addr,
  input wire logic [sysbus_pkg::REG_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [sysbus_pkg::REG_DW-1:0] reg_rdata,
  // Address arbitration
  input wire logic bus_grant_n,
  input wire logic address_acknowledge_n,
  output logic bus_request_n,
  output logic addr_bus_busy_n,
  output logic addr_bus_monitor_n,
  // Transfer start pin
  input wire logic transfer_start_n,
  output logic transfer_start_o,
  output logic transfer_start_oe,
  // Address retry pin
  input wire logic address_retry_n,
  output logic address_retry_o,
  output logic address_retry_oe,
  // Address bus drive enable
  output logic addr_oe,
  // Snoop responses
  output logic intervention_hit_n,
  output logic shared_ind_a_n,
  output logic shared_ind_b_n,
  output logic data_ready_out_n,
  // Local transaction queue
  input wire logic txn_valid,
  input wire logic txn_more,
  output logic txn_start,
  // Cache snoop side
  input wire logic snoop_valid,
  input wire logic snoop_hit_l1,
  input wire logic snoop_hit_l2,
  input wire logic snoop_modified,
  input wire logic snoop_shared,
  input wire logic intv_beat_valid,
  input wire logic intv_beat_last,
  output logic flush_req
);
  import sysbus_pkg::*;

  logic hard_reset_n_s;
  logic strap_s;
  logic hard_reset_n_prev_q;
  logic ext_mode_q;
  logic abd_q;
  logic l1_intv_en_q;
  logic l2_intv_en_q;
  logic tenure_q;
  logic [1:0] ts_cnt_q;
  logic qualified_grant;
  logic start_d;
  logic bus_request_d;
  logic busy_d;
  logic addr_oe_d;
  logic intv_pend;

  // ----------------------------------------
  // Strap capture
  // ----------------------------------------
  pin_sync3 #(
    .RESET_VAL(1'b0)
  ) u_sync_hard_reset_n (
    .core_clk(core_clk),
    .resetn(resetn),
    .pin_in(hard_reset_n),
    .level_q(hard_reset_n_s)
  );

  pin_sync3 #(
    .RESET_VAL(1'b1)
  ) u_sync_strap (
    .core_clk(core_clk),
    .resetn(resetn),
    .pin_in(bus_mode_strap_n),
    .level_q(strap_s)
  );

  // Mode is caught at the rising edge of the filtered hard reset
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      hard_reset_n_prev_q <= 1'b0;
      ext_mode_q <= 1'b0;
      abd_q <= 1'b0;
    end
    else
    begin
      hard_reset_n_prev_q <= hard_reset_n_s;
      if (hard_reset_n_s && !hard_reset_n_prev_q)
      begin
        ext_mode_q <= !strap_s;
        abd_q <= !strap_s;
      end
    end
  end

  // ----------------------------------------
  // Grant qualification and start
  // ----------------------------------------
  // Own tenure blocks until acknowledge, so streaming can qualify in the ack cycle
  assign qualified_grant = !bus_grant_n && address_retry_n && transfer_start_n
                           && !(tenure_q && address_acknowledge_n)
                           && (ts_cnt_q == 2'h0);
  // Start follows a grant qualified now; strobe appears next cycle
  assign start_d = qualified_grant && txn_valid && hard_reset_n_s;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tenure_q <= 1'b0;
    end
    else if (start_d)
    begin
      tenure_q <= 1'b1;
    end
    else if (!address_acknowledge_n)
    begin
      tenure_q <= 1'b0;
    end
  end

  // Strobe low for one cycle, high for one, then released
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ts_cnt_q <= 2'h0;
      transfer_start_o <= 1'b1;
      transfer_start_oe <= 1'b0;
      txn_start <= 1'b0;
    end
    else
    begin
      txn_start <= start_d;
      if (start_d)
      begin
        ts_cnt_q <= TS_DRIVE_CYCLES;
        transfer_start_o <= 1'b0;
        transfer_start_oe <= 1'b1;
      end
      else if (ts_cnt_q != 2'h0)
      begin
        ts_cnt_q <= ts_cnt_q - 2'h1;
        transfer_start_o <= 1'b1;
        transfer_start_oe <= (ts_cnt_q > 2'h1);
      end
    end
  end

  // ----------------------------------------
  // Bus request
  // ----------------------------------------
  always_comb
  begin
    if (start_d)
    begin
      bus_request_d = ext_mode_q ? txn_more : 1'b1;
    end
    else
    begin
      bus_request_d = txn_valid && hard_reset_n_s && !tenure_q;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bus_request_n <= 1'b1;
    end
    else
    begin
      bus_request_n <= !bus_request_d;
    end
  end

  // ----------------------------------------
  // Address busy and monitor
  // ----------------------------------------
  // Busy spans the start strobe up to and including the acknowledge cycle
  assign busy_d = start_d || (tenure_q && address_acknowledge_n);

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      addr_bus_busy_n <= 1'b1;
      addr_bus_monitor_n <= 1'b1;
    end
    else
    begin
      addr_bus_busy_n <= !(busy_d && !ext_mode_q);
      addr_bus_monitor_n <= !(busy_d && ext_mode_q);
    end
  end

  // ----------------------------------------
  // Address bus drive
  // ----------------------------------------
  always_comb
  begin
    addr_oe_d = addr_oe;
    if (!address_acknowledge_n && !qualified_grant)
    begin
      addr_oe_d = 1'b0;
    end
    if (start_d)
    begin
      addr_oe_d = 1'b1;
    end
    if (abd_q && ext_mode_q && !bus_grant_n)
    begin
      addr_oe_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      addr_oe <= 1'b0;
    end
    else
    begin
      addr_oe <= addr_oe_d;
    end
  end

  // ----------------------------------------
  // Snoop response
  // ----------------------------------------
  snoop_responder u_snoop (
    .core_clk(core_clk),
    .resetn(resetn),
    .ext_mode(ext_mode_q),
    .l1_intv_en(l1_intv_en_q),
    .l2_intv_en(l2_intv_en_q),
    .snoop_valid(snoop_valid),
    .snoop_hit_l1(snoop_hit_l1),
    .snoop_hit_l2(snoop_hit_l2),
    .snoop_modified(snoop_modified),
    .snoop_shared(snoop_shared),
    .address_acknowledge_n(address_acknowledge_n),
    .intv_beat_valid(intv_beat_valid),
    .intv_beat_last(intv_beat_last),
    .intervention_hit_n(intervention_hit_n),
    .address_retry_o(address_retry_o),
    .address_retry_oe(address_retry_oe),
    .shared_ind_a_n(shared_ind_a_n),
    .shared_ind_b_n(shared_ind_b_n),
    .data_ready_out_n(data_ready_out_n),
    .flush_req(flush_req),
    .intv_pend_q(intv_pend)
  );

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      l1_intv_en_q <= CTL_L1_INTV_RST;
      l2_intv_en_q <= CTL_L2_INTV_RST;
    end
    else if (reg_wr && reg_addr == MEM_SUBSYS_CONTROL_OFS)
    begin
      l1_intv_en_q <= reg_wdata[CTL_L1_INTV_BIT];
      l2_intv_en_q <= reg_wdata[CTL_L2_INTV_BIT];
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      reg_rdata <= '0;
    end
    else
    begin
      reg_rdata <= '0;
      if (reg_rd && reg_addr == MEM_SUBSYS_CONTROL_OFS)
      begin
        reg_rdata[CTL_MODE_BIT] <= ext_mode_q;
        reg_rdata[CTL_ABD_BIT] <= abd_q;
        reg_rdata[CTL_L1_INTV_BIT] <= l1_intv_en_q;
        reg_rdata[CTL_L2_INTV_BIT] <= l2_intv_en_q;
      end
      else if (reg_rd && reg_addr == BUS_STATUS_OFS)
      begin
        reg_rdata[STS_TENURE_BIT] <= tenure_q;
        reg_rdata[STS_INTV_PEND_BIT] <= intv_pend;
        reg_rdata[STS_ADDR_OE_BIT] <= addr_oe;
        reg_rdata[STS_REQ_BIT] <= !bus_request_n;
      end
    end
  end

endmodule // sysbus_grant_snoop

// ---- tb/sysbus_chk.sv ----
// Concurrent assertions on the ports of the bus grant and snoop block
`timescale 1ns/1ps

module sysbus_chk (
  // Clock and reset
  input logic core_clk, resetn,
  // Arbitration and start
  input logic bus_grant_n, address_acknowledge_n, bus_request_n, txn_valid, txn_more,
  input logic addr_bus_busy_n, addr_bus_monitor_n, addr_oe, txn_start,
  input logic transfer_start_n, transfer_start_o, transfer_start_oe, address_retry_n,
  // Snoop responses
  input logic address_retry_o, address_retry_oe, flush_req, intervention_hit_n,
  input logic shared_ind_a_n, shared_ind_b_n, data_ready_out_n, intv_beat_valid
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // ----------------------------------------
  // Address tenure
  // ----------------------------------------
  sequence ts_low_s;
    !transfer_start_o && transfer_start_oe;
  endsequence
  sequence ts_high_s;
    transfer_start_o && transfer_start_oe;
  endsequence

  ts_shape_a: assert property (txn_start |-> ts_low_s ##1 ts_high_s ##1 !transfer_start_oe)
    else $error("start strobe shape wrong");
  grant_qual_a: assert property (txn_start |->
    $past(!bus_grant_n && address_retry_n && transfer_start_n && txn_valid))
    else $error("start without qualified grant");
  req_drop_a: assert property (txn_start && !addr_bus_monitor_n |->
    bus_request_n == !$past(txn_more))
    else $error("request level wrong in start cycle");
  start_busy_a: assert property (txn_start |-> addr_bus_busy_n ^ addr_bus_monitor_n)
    else $error("busy or monitor wrong at start");
  addr_rel_a: assert property (!address_acknowledge_n && bus_grant_n |=>
    !addr_oe && addr_bus_busy_n && addr_bus_monitor_n)
    else $error("address bus kept after acknowledge");

  // ----------------------------------------
  // Snoop window
  // ----------------------------------------
  hit_win_a: assert property (!intervention_hit_n |->
    $past(!address_acknowledge_n) && !address_retry_oe)
    else $error("hit outside retry window");
  retry_flush_a: assert property (address_retry_oe |->
    !address_retry_o && flush_req && $past(!address_acknowledge_n) ##1 !address_retry_oe)
    else $error("retry without flush or outside window");
  shd_pair_a: assert property (!shared_ind_b_n |->
    !shared_ind_a_n && $past(!address_acknowledge_n))
    else $error("second shared line alone");
  data_ready_out_n_beat_a: assert property (!data_ready_out_n |-> $past(intv_beat_valid))
    else $error("data ready without beat");
endmodule // sysbus_chk

bind sysbus_grant_snoop sysbus_chk sysbus_chk_i (.core_clk, .resetn, .bus_grant_n,
  .address_acknowledge_n, .bus_request_n, .txn_valid, .txn_more, .addr_bus_busy_n,
  .addr_bus_monitor_n, .addr_oe, .txn_start, .transfer_start_n, .transfer_start_o,
  .transfer_start_oe, .address_retry_n, .address_retry_o, .address_retry_oe, .flush_req,
  .intervention_hit_n, .shared_ind_a_n, .shared_ind_b_n, .data_ready_out_n, .intv_beat_valid);

// ---- tb/arb_model.sv ----
// Behavioural system bus arbiter facing the block
`timescale 1ns/1ps

module arb_model (
  // Clock and reset
  input logic core_clk,
  input logic resetn,
  // Bench controls
  input logic grant_en,
  input logic ack_req,
  input logic [3:0] ack_wait,
  // Bus
  input logic transfer_start_n,
  output logic bus_grant_n,
  output logic address_acknowledge_n
);
  logic pend_q;
  logic [3:0] wait_q;

  // Grant stays off from start until the ack cycle, so no second qualification slips in
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
      bus_grant_n <= 1'h1;
    else
      bus_grant_n <= !(grant_en && !pend_q && transfer_start_n);

  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
    begin
      pend_q <= 1'h0;
      wait_q <= 4'h0;
      address_acknowledge_n <= 1'h1;
    end
    else
    begin
      address_acknowledge_n <= !(ack_req || (pend_q && wait_q == 4'h0));
      if (!transfer_start_n && !pend_q)
      begin
        pend_q <= 1'h1;
        wait_q <= ack_wait;
      end
      else if (pend_q && wait_q == 4'h0)
        pend_q <= 1'h0;
      else if (pend_q)
        wait_q <= wait_q - 4'h1;
    end
endmodule // arb_model

// ---- tb/tb_top.sv ----
// Self-checking testbench for the bus grant and snoop block
`timescale 1ns/1ps

module tb_top;
  import sysbus_pkg::*;

  logic core_clk = 1'h0;
  logic resetn = 1'h0;
  logic hard_reset_n = 1'h0;
  logic bus_mode_strap_n = 1'h1;
  logic [REG_AW-1:0] reg_addr = '0;
  logic [REG_DW-1:0] reg_wdata = '0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [REG_DW-1:0] reg_rdata;
  logic bus_grant_n, address_acknowledge_n, bus_request_n, addr_bus_busy_n, addr_bus_monitor_n;
  logic transfer_start_n, transfer_start_o, transfer_start_oe, addr_oe, txn_start, flush_req;
  logic address_retry_n, address_retry_o, address_retry_oe, intervention_hit_n;
  logic shared_ind_a_n, shared_ind_b_n, data_ready_out_n;
  logic txn_valid = 1'h0, txn_more = 1'h0, snoop_valid = 1'h0;
  logic snoop_hit_l1 = 1'h0, snoop_hit_l2 = 1'h0, snoop_modified = 1'h0, snoop_shared = 1'h0;
  logic intv_beat_valid = 1'h0, intv_beat_last = 1'h0;
  logic grant_en = 1'h0, ack_req = 1'h0, other_retry_n = 1'h1;
  logic [3:0] ack_wait = 4'h2;
  int errors = 0;
  int num_checks = 0;
  int n;

  initial
    forever #50 core_clk = ~core_clk;

  // Pulled-up shared pins; another master may pull retry low
  assign transfer_start_n = transfer_start_oe ? transfer_start_o : 1'h1;
  assign address_retry_n = (address_retry_oe ? address_retry_o : 1'h1) & other_retry_n;

  sysbus_grant_snoop sysbus_grant_snoop_i (.core_clk, .resetn, .hard_reset_n,
    .bus_mode_strap_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .bus_grant_n,
    .address_acknowledge_n, .bus_request_n, .addr_bus_busy_n, .addr_bus_monitor_n,
    .transfer_start_n, .transfer_start_o, .transfer_start_oe, .address_retry_n,
    .address_retry_o, .address_retry_oe, .addr_oe, .intervention_hit_n, .shared_ind_a_n,
    .shared_ind_b_n, .data_ready_out_n, .txn_valid, .txn_more, .txn_start, .snoop_valid,
    .snoop_hit_l1, .snoop_hit_l2, .snoop_modified, .snoop_shared, .intv_beat_valid,
    .intv_beat_last, .flush_req);
  arb_model arb_model_i (.core_clk, .resetn, .grant_en, .ack_req, .ack_wait,
    .transfer_start_n, .bus_grant_n, .address_acknowledge_n);

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask

  task automatic reg_read(input logic [7:0] a, input logic [31:0] exp, input string nm);
    @(posedge core_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    @(negedge core_clk);
    chk(nm, exp, reg_rdata);
  endtask

  // Strap must stay put until the filtered hard reset has risen
  task automatic boot(input logic strap_n);
    @(posedge core_clk);
    resetn <= 1'h0;
    hard_reset_n <= 1'h0;
    bus_mode_strap_n <= strap_n;
    repeat (2) @(posedge core_clk);
    resetn <= 1'h1;
    @(posedge core_clk);
    hard_reset_n <= 1'h1;
    repeat (8) @(posedge core_clk);
  endtask

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_mode(input logic [1:0] m);
    reg_read(MEM_SUBSYS_CONTROL_OFS, {30'h0, m}, "control after boot");
    reg_write(MEM_SUBSYS_CONTROL_OFS, 32'hFFFFFFFF);
    reg_read(MEM_SUBSYS_CONTROL_OFS, {28'h0, 2'h3, m}, "control read-only bits");
    reg_read(8'h08, 32'h0, "unmapped word");
    reg_read(BUS_STATUS_OFS, 32'h0, "idle status");
    $display("mode test done, mode %0d", m);
  endtask

  task automatic t_start(input logic more, input logic exp_req, input logic ext);
    @(posedge core_clk);
    txn_valid <= 1'h1;
    txn_more <= more;
    grant_en <= 1'h1;
    n = 0;
    do
    begin
      @(negedge core_clk);
      n++;
    end while (txn_start !== 1'h1 && n < 10);
    chk("txn_start", 32'h1, txn_start);
    chk("bus_request_n", exp_req, bus_request_n);
    chk("addr_bus_monitor_n", !ext, addr_bus_monitor_n);
    chk("addr_bus_busy_n", ext, addr_bus_busy_n);
    @(posedge core_clk);
    txn_valid <= 1'h0;
    grant_en <= 1'h0;
    n = 0;
    do
    begin
      @(negedge core_clk);
      n++;
    end while (address_acknowledge_n !== 1'h0 && n < 20);
    @(negedge core_clk);
    chk("addr_oe after ack", 32'h0, addr_oe);
    chk("monitor after ack", 32'h1, addr_bus_monitor_n);
    $display("start test done, more %0d", more);
  endtask

  task automatic t_qual;
    @(posedge core_clk);
    other_retry_n <= 1'h0;
    txn_valid <= 1'h1;
    txn_more <= 1'h0;
    grant_en <= 1'h1;
    repeat (5)
    begin
      @(negedge core_clk);
      chk("start under retry", 32'h0, txn_start);
    end
    @(posedge core_clk);
    other_retry_n <= 1'h1;
    t_start(1'h0, 1'h1, 1'h1);
    $display("qualification test done");
  endtask

  task automatic t_abd(input logic exp);
    @(posedge core_clk);
    grant_en <= 1'h1;
    @(posedge core_clk);
    grant_en <= 1'h0;
    @(negedge core_clk);
    chk("addr_oe in grant cycle", 32'h0, addr_oe);
    @(negedge core_clk);
    chk("addr_oe after grant", exp, addr_oe);
    repeat (3) @(posedge core_clk);
    $display("driven mode test done");
  endtask

  // s = {l1 hit, l2 hit, modified, shared}; e = {hit_n, retry_oe, shared a_n, shared b_n}
  task automatic t_snoop(input logic [3:0] s, input logic [1:0] en, input logic [3:0] e);
    reg_write(MEM_SUBSYS_CONTROL_OFS, {28'h0, en, 2'h0});
    @(posedge core_clk);
    {snoop_hit_l1, snoop_hit_l2, snoop_modified, snoop_shared} <= s;
    snoop_valid <= 1'h1;
    ack_req <= 1'h1;
    @(posedge core_clk);
    snoop_valid <= 1'h0;
    ack_req <= 1'h0;
    @(posedge core_clk);
    @(negedge core_clk);
    chk("snoop response", e, {intervention_hit_n, address_retry_oe, shared_ind_a_n,
      shared_ind_b_n});
    chk("flush_req", e[2], flush_req);
    if (!e[3])
    begin
      @(posedge core_clk);
      intv_beat_valid <= 1'h1;
      intv_beat_last <= 1'h1;
      @(posedge core_clk);
      intv_beat_valid <= 1'h0;
      intv_beat_last <= 1'h0;
      @(negedge core_clk);
      chk("data_ready_out_n", 32'h0, data_ready_out_n);
    end
    $display("snoop test done, case %h", s);
  endtask

  initial
  begin
    repeat (5000) @(posedge core_clk);
    errors++;
    $display("MISMATCH watchdog expected done seen hung");
    end_sim;
  end

  initial
  begin
    boot(1'h1);
    t_mode(2'h0);
    t_start(1'h0, 1'h0, 1'h0);
    t_abd(1'h0);
    t_snoop(4'hA, 2'h3, 4'hF);
    t_snoop(4'h9, 2'h0, 4'h9);
    boot(1'h0);
    t_mode(2'h3);
    t_start(1'h0, 1'h1, 1'h1);
    t_start(1'h1, 1'h0, 1'h1);
    t_qual;
    t_abd(1'h1);
    t_snoop(4'h8, 2'h1, 4'h3);
    t_snoop(4'h4, 2'h2, 4'h3);
    t_snoop(4'hA, 2'h2, 4'hF);
    t_snoop(4'h6, 2'h0, 4'hF);
    t_snoop(4'h9, 2'h0, 4'h8);
    end_sim;
  end
endmodule // tb_top
